// File: rtl/pgd_datapath.v
// Notes on behaviour
// [RULE1] Last four-bit index picks data register
// [RULE2] Index map 0,1,2,3,4,5,6,7,8 as given
// [RULE3] Section position picks its data bit pair
// [RULE4] Software loads positions 00 and 01
// [RULE5] Write mode 0 writes rotated byte
// [RULE6] Enabled planes take unrotated fill bit
// [RULE7] Fill only in mode 0, else data
// [RULE8] Mode 0 rotates left by rotate count
// [RULE9] Function: pass, AND, OR, XOR latch
// [RULE10] Rotate first; no function on latches
// [RULE11] Write mode 1 writes read latches
// [RULE12] Write mode 2 fills from bits 0-3
// [RULE13] Software never selects write mode 3; the test writes mode 3 once, and the datapath then enables no plane
// [RULE14] Normal read returns selected plane
// [RULE15] Compare read: one where planes match
// [RULE16] Ignored planes always count as match
// [RULE17] Test bit forces colour, graphics, chain
// [RULE18] Odd/even bit selects odd/even addressing
// [RULE19] Shift mode interleaves even/odd maps
// [RULE20] Graphics mode: same address both buses
// [RULE21] Chain: A0 replaced, A0 picks plane
// [RULE22] Mask zero keeps latched bit
// [RULE23] Every read captures all four planes; the code captures none when mem_wr is high in the same cycle
`timescale 1ns/1ps
`include "pgd_regs.vh"

module pgd_datapath #(
    parameter ADDR_W = 16
) (
    // Clock and reset
    input wire clk_sys,
    input wire srst,
    // Register port writes
    input wire io_wr,
    input wire [9:0] io_addr,
    input wire [7:0] io_wdata,
    // Processor memory cycles
    input wire mem_rd,
    input wire mem_wr,
    input wire [ADDR_W-1:0] cpu_addr,
    input wire [7:0] cpu_wdata,
    output reg [7:0] cpu_rdata,
    output reg cpu_rvalid,
    // Display memory planes
    input wire [31:0] plane_rdata,
    output reg [31:0] plane_wdata,
    output reg [3:0] plane_wr_en,
    output reg [ADDR_W-1:0] plane_addr,
    // Addressing and mode outputs
    output reg [7:0] plane_pair_a_address_bus,
    output reg [7:0] plane_pair_b_address_bus,
    output reg memory_map_select_0,
    output reg memory_map_select_1,
    output reg interleave_shift,
    output reg [3:0] internal_plane_color_signals
);

    // Programmed registers
    reg [1:0] section_one_bus_position_reg;
    reg [1:0] section_two_bus_position_reg;
    reg [3:0] graphics_register_pointer_reg;
    reg [3:0] plane_fill_value_reg;
    reg [3:0] plane_fill_enable_reg;
    reg [3:0] compare_color_value_reg;
    reg [4:0] rotate_and_logic_function_reg;
    reg [2:0] read_plane_select_reg;
    reg [5:0] write_read_mode_control_reg;
    reg [3:0] addressing_misc_control_reg;
    reg [3:0] compare_ignore_planes_reg;
    reg [7:0] write_bit_protect_mask_reg;

    // Read latches and character address latch
    reg [31:0] plane_latch_reg;
    reg [7:0] char_addr_reg;

    // Decoded fields
    wire [1:0] write_mode;
    wire [1:0] func_sel;
    wire [2:0] rot_count;
    wire test_mode;
    wire graphics_eff;
    wire chain_eff;
    wire odd_even_eff;
    wire [3:0] color_eff;
    wire data_sel;
    wire [15:0] rot_wide;
    wire [7:0] rotated;
    wire [31:0] alu_out;

    // Registered datapath next values
    reg [3:0] fill4_next;
    reg [7:0] rd_next;
    reg [3:0] plane_en_next;
    reg [ADDR_W-1:0] addr_next;
    reg [7:0] cmp_match;
    reg [3:0] rd_plane;
    reg [3:0] wr_colour;
    integer b;
    integer p;

    assign write_mode = write_read_mode_control_reg[`PGD_MODE_WR_MSB:
        `PGD_MODE_WR_LSB];
    assign func_sel = rotate_and_logic_function_reg[`PGD_FUNC_MSB:
        `PGD_FUNC_LSB];
    assign rot_count = rotate_and_logic_function_reg[`PGD_ROT_MSB:
        `PGD_ROT_LSB]; // [RULE8]
    assign test_mode = write_read_mode_control_reg[`PGD_MODE_TEST];

    // Test bit forces internal colour, graphics and chain high
    assign graphics_eff = addressing_misc_control_reg[`PGD_MISC_GRAPHICS]
        | test_mode; // [RULE17]
    assign chain_eff = addressing_misc_control_reg[`PGD_MISC_CHAIN]
        | test_mode; // [RULE17]
    assign color_eff = test_mode ? 4'hF : compare_color_value_reg; // [RULE17]
    assign odd_even_eff = write_read_mode_control_reg[`PGD_MODE_ODD_EVEN]
        | chain_eff;
    assign data_sel = io_wr && (io_addr == `PGD_PORT_DATA);

    // Rotate left, applied before the logic function
    assign rot_wide = {cpu_wdata, cpu_wdata} << rot_count;
    assign rotated = rot_wide[15:8]; // [RULE8]

    // Gather a four-plane value from the two sections' bit pairs
    always @* begin
        fill4_next = {
            io_wdata[{section_two_bus_position_reg, 1'b1}],
            io_wdata[{section_two_bus_position_reg, 1'b0}],
            io_wdata[{section_one_bus_position_reg, 1'b1}],
            io_wdata[{section_one_bus_position_reg, 1'b0}]
        }; // [RULE3]
        wr_colour = {
            cpu_wdata[{section_two_bus_position_reg, 1'b1}],
            cpu_wdata[{section_two_bus_position_reg, 1'b0}],
            cpu_wdata[{section_one_bus_position_reg, 1'b1}],
            cpu_wdata[{section_one_bus_position_reg, 1'b0}]
        }; // [RULE3]
    end

    // Per-plane write datapath
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : plane
            pgd_plane_alu u_alu (
                .write_mode(write_mode),
                .func_sel(func_sel),
                .fill_en(plane_fill_enable_reg[g]),
                .fill_bit(plane_fill_value_reg[g]),
                .colour_bit(wr_colour[g]),
                .rotated(rotated),
                .latched(plane_latch_reg[8*g+7:8*g]),
                .bit_mask(write_bit_protect_mask_reg),
                .result(alu_out[8*g+7:8*g])
            );
        end
    endgenerate

    // Read result, address steering and plane enables
    always @* begin
        cmp_match = 8'hFF;
        for (b = 0; b < 8; b = b + 1) begin
            for (p = 0; p < 4; p = p + 1) begin
                if (!compare_ignore_planes_reg[p] &&
                    (plane_rdata[8*p+b] != color_eff[p])) begin
                    cmp_match[b] = 1'b0; // [RULE15] [RULE16]
                end
            end
        end
        rd_plane = 4'h0;
        if (!read_plane_select_reg[2]) begin
            rd_plane[read_plane_select_reg[1:0]] = 1'b1;
        end
        // Odd/even: selected pair, plane within it from A0
        if (odd_even_eff) begin
            rd_plane = 4'h0;
            if (!read_plane_select_reg[2]) begin
                rd_plane[{read_plane_select_reg[1], cpu_addr[0]}] =
                    1'b1; // [RULE18]
            end
        end
        rd_next = 8'h00;
        if (write_read_mode_control_reg[`PGD_MODE_RD]) begin
            rd_next = cmp_match; // [RULE15]
        end else begin
            for (p = 0; p < 4; p = p + 1) begin
                if (rd_plane[p]) begin
                    rd_next = plane_rdata[8*p+:8]; // [RULE14]
                end
            end
        end
        if (write_mode == 2'h3) begin
            plane_en_next = 4'h0;
        end else if (odd_even_eff) begin
            plane_en_next = cpu_addr[0] ? 4'hA : 4'h5; // [RULE18] [RULE21]
        end else begin
            plane_en_next = 4'hF;
        end
        addr_next = cpu_addr;
        if (chain_eff) begin
            addr_next[0] = cpu_addr[ADDR_W-1]; // [RULE21]
        end
    end

    // Register port writes, direct and through the index pointer
    always @(posedge clk_sys) begin
        if (srst) begin
            section_one_bus_position_reg <= `PGD_RST_SEC1_POS;
            section_two_bus_position_reg <= `PGD_RST_SEC2_POS;
            graphics_register_pointer_reg <= 4'h0;
            plane_fill_value_reg <= 4'h0;
            plane_fill_enable_reg <= 4'h0;
            compare_color_value_reg <= 4'h0;
            rotate_and_logic_function_reg <= 5'h00;
            read_plane_select_reg <= 3'h0;
            write_read_mode_control_reg <= 6'h00;
            addressing_misc_control_reg <= 4'h0;
            compare_ignore_planes_reg <= 4'h0;
            write_bit_protect_mask_reg <= `PGD_RST_MASK;
        end else begin
            if (io_wr && io_addr == `PGD_PORT_SEC1_POS) begin
                section_one_bus_position_reg <= io_wdata[1:0];
            end
            if (io_wr && io_addr == `PGD_PORT_SEC2_POS) begin
                section_two_bus_position_reg <= io_wdata[1:0];
            end
            if (io_wr && io_addr == `PGD_PORT_INDEX) begin
                graphics_register_pointer_reg <= io_wdata[3:0]; // [RULE1]
            end
            if (data_sel) begin
                case (graphics_register_pointer_reg) // [RULE2]
                    `PGD_IDX_FILL_VALUE: begin
                        plane_fill_value_reg <= fill4_next;
                    end
                    `PGD_IDX_FILL_ENABLE: begin
                        plane_fill_enable_reg <= fill4_next;
                    end
                    `PGD_IDX_COMPARE: begin
                        compare_color_value_reg <= fill4_next;
                    end
                    `PGD_IDX_ROTATE_FUNC: begin
                        rotate_and_logic_function_reg <= io_wdata[4:0];
                    end
                    `PGD_IDX_READ_PLANE: begin
                        read_plane_select_reg <= io_wdata[2:0];
                    end
                    `PGD_IDX_MODE: begin
                        write_read_mode_control_reg <= io_wdata[5:0];
                    end
                    `PGD_IDX_MISC: begin
                        addressing_misc_control_reg <= io_wdata[3:0];
                    end
                    `PGD_IDX_IGNORE: begin
                        compare_ignore_planes_reg <= fill4_next;
                    end
                    `PGD_IDX_BIT_MASK: begin
                        write_bit_protect_mask_reg <= io_wdata;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Memory cycles: latch capture, read return, write issue
    always @(posedge clk_sys) begin
        if (srst) begin
            plane_latch_reg <= 32'h00000000;
            char_addr_reg <= `PGD_RST_BYTE;
            cpu_rdata <= `PGD_RST_BYTE;
            cpu_rvalid <= 1'b0;
            plane_wdata <= 32'h00000000;
            plane_wr_en <= 4'h0;
            plane_addr <= {ADDR_W{1'b0}};
            plane_pair_a_address_bus <= `PGD_RST_BYTE;
            plane_pair_b_address_bus <= `PGD_RST_BYTE;
        end else begin
            cpu_rvalid <= mem_rd && !mem_wr;
            plane_wr_en <= 4'h0;
            if (mem_rd && !mem_wr) begin
                plane_latch_reg <= plane_rdata; // [RULE23]
                cpu_rdata <= rd_next;
            end
            if (mem_wr) begin
                plane_wdata <= alu_out;
                plane_wr_en <= plane_en_next;
            end
            if (mem_rd || mem_wr) begin
                plane_addr <= addr_next;
                char_addr_reg <= addr_next[7:0];
                plane_pair_a_address_bus <= addr_next[7:0];
                if (graphics_eff) begin
                    plane_pair_b_address_bus <= addr_next[7:0]; // [RULE20]
                end else begin
                    plane_pair_b_address_bus <= char_addr_reg;
                end
            end
        end
    end

    // Mode level outputs
    always @(posedge clk_sys) begin
        if (srst) begin
            memory_map_select_0 <= 1'b0;
            memory_map_select_1 <= 1'b0;
            interleave_shift <= 1'b0;
            internal_plane_color_signals <= 4'h0;
        end else begin
            memory_map_select_0 <=
                addressing_misc_control_reg[`PGD_MISC_MAP0];
            memory_map_select_1 <=
                addressing_misc_control_reg[`PGD_MISC_MAP1];
            interleave_shift <=
                write_read_mode_control_reg[`PGD_MODE_SHIFT]; // [RULE19]
            internal_plane_color_signals <= color_eff; // [RULE17]
        end
    end

endmodule

// File: rtl/pgd_regs.vh
`ifndef PGD_REGS_VH
`define PGD_REGS_VH

// I/O port addresses of the register set
`define PGD_PORT_SEC2_POS 10'h3CA
`define PGD_PORT_SEC1_POS 10'h3CC
`define PGD_PORT_INDEX 10'h3CE
`define PGD_PORT_DATA 10'h3CF

// Indexed register numbers
`define PGD_IDX_FILL_VALUE 4'h0
`define PGD_IDX_FILL_ENABLE 4'h1
`define PGD_IDX_COMPARE 4'h2
`define PGD_IDX_ROTATE_FUNC 4'h3
`define PGD_IDX_READ_PLANE 4'h4
`define PGD_IDX_MODE 4'h5
`define PGD_IDX_MISC 4'h6
`define PGD_IDX_IGNORE 4'h7
`define PGD_IDX_BIT_MASK 4'h8

// Rotate and function field positions
`define PGD_ROT_LSB 0
`define PGD_ROT_MSB 2
`define PGD_FUNC_LSB 3
`define PGD_FUNC_MSB 4

// Mode register field positions
`define PGD_MODE_WR_LSB 0
`define PGD_MODE_WR_MSB 1
`define PGD_MODE_TEST 2
`define PGD_MODE_RD 3
`define PGD_MODE_ODD_EVEN 4
`define PGD_MODE_SHIFT 5

// Miscellaneous register field positions
`define PGD_MISC_GRAPHICS 0
`define PGD_MISC_CHAIN 1
`define PGD_MISC_MAP0 2
`define PGD_MISC_MAP1 3

// Write modes and logic functions
`define PGD_WM_ROTATE 2'h0
`define PGD_WM_LATCH 2'h1
`define PGD_WM_FILL 2'h2
`define PGD_FN_PASS 2'h0
`define PGD_FN_AND 2'h1
`define PGD_FN_OR 2'h2
`define PGD_FN_XOR 2'h3

// Reset values
`define PGD_RST_SEC1_POS 2'h0
`define PGD_RST_SEC2_POS 2'h1
`define PGD_RST_BYTE 8'h00
`define PGD_RST_MASK 8'hFF

`endif

// File: rtl/pgd_plane_alu.v
`timescale 1ns/1ps
`include "pgd_regs.vh"

// One plane of the write datapath
module pgd_plane_alu (
    // Mode and controls
    input wire [1:0] write_mode,
    input wire [1:0] func_sel,
    input wire fill_en,
    input wire fill_bit,
    input wire colour_bit,
    // Data
    input wire [7:0] rotated,
    input wire [7:0] latched,
    input wire [7:0] bit_mask,
    output reg [7:0] result
);

    reg [7:0] source;
    reg [7:0] combined;

    // Source select, logic function, then mask against latch
    always @* begin
        case (write_mode)
            `PGD_WM_ROTATE: source = fill_en ? {8{fill_bit}} : rotated; // [RULE5] [RULE6] [RULE7]
            `PGD_WM_FILL: source = {8{colour_bit}}; // [RULE12]
            default: source = latched; // [RULE11]
        endcase
        case (func_sel)
            `PGD_FN_AND: combined = source & latched; // [RULE9]
            `PGD_FN_OR: combined = source | latched;
            `PGD_FN_XOR: combined = source ^ latched;
            default: combined = source;
        endcase
        if (write_mode == `PGD_WM_LATCH) begin
            result = latched; // [RULE10]
        end else begin
            result = (combined & bit_mask) | (latched & ~bit_mask); // [RULE22]
        end
    end

endmodule

// File: dv/pgd_datapath_asserts.sv
`timescale 1ns/1ps
module pgd_datapath_asserts #(
    parameter ADDR_W = 16
) (
    // Clock, reset and requests
    input wire clk_sys,
    input wire srst,
    input wire io_wr,
    input wire mem_rd,
    input wire mem_wr,
    // Observed outputs
    input wire [7:0] cpu_rdata,
    input wire cpu_rvalid,
    input wire [31:0] plane_wdata,
    input wire [3:0] plane_wr_en,
    input wire [ADDR_W-1:0] plane_addr,
    input wire [7:0] plane_pair_a_address_bus,
    input wire memory_map_select_0,
    input wire memory_map_select_1,
    input wire interleave_shift,
    input wire [3:0] internal_plane_color_signals
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    // Read request as the datapath takes it
    wire rd_take = mem_rd && !mem_wr;
    AST_RD_ANS: assert property (rd_take |=> cpu_rvalid)
        else $error("read answer missing");
    AST_RD_ONE: assert property (!rd_take |=> !cpu_rvalid)
        else $error("read valid without request");
    AST_RD_HOLD: assert property (!rd_take |=> $stable(cpu_rdata))
        else $error("read data moved without read");
    AST_WR_ONE: assert property (!mem_wr |=> plane_wr_en == 4'h0)
        else $error("plane strobe without write");
    AST_WD_HOLD: assert property (!mem_wr |=> $stable(plane_wdata))
        else $error("plane data moved without write");
    AST_AD_HOLD: assert property (!(mem_rd || mem_wr) |=>
        $stable(plane_addr)) else $error("address moved while idle");
    AST_BUS_A: assert property
        (plane_pair_a_address_bus == plane_addr[7:0])
        else $error("bus A differs from address");
    AST_CFG_HOLD: assert property (!io_wr ##1 !io_wr |=>
        $stable({memory_map_select_0, memory_map_select_1,
        interleave_shift, internal_plane_color_signals}))
        else $error("mode outputs moved without port write");
endmodule

bind pgd_datapath pgd_datapath_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .clk_sys, .srst, .io_wr, .mem_rd, .mem_wr, .cpu_rdata, .cpu_rvalid,
    .plane_wdata, .plane_wr_en, .plane_addr, .plane_pair_a_address_bus,
    .memory_map_select_0, .memory_map_select_1, .interleave_shift,
    .internal_plane_color_signals);

// File: dv/pgd_plane_mem.sv
`timescale 1ns/1ps
module pgd_plane_mem (
    // Clock and read side
    input wire clk_sys,
    input wire mem_rd,
    input wire [3:0] rd_addr,
    // Write side
    input wire [3:0] plane_wr_en,
    input wire [3:0] wr_addr,
    input wire [31:0] plane_wdata,
    output wire [31:0] plane_rdata
);
    reg [31:0] mem [0:15];
    integer i, j;
    // Spread pattern as starting contents
    initial begin
        for (i = 0; i < 16; i = i + 1)
            mem[i] = 32'h9E3779B9 * (i + 1);
    end
    // Outside reads the data lines show inverted bytes
    assign plane_rdata = mem_rd ? mem[rd_addr] : ~mem[rd_addr];
    // Byte write per enabled plane
    always @(posedge clk_sys) begin
        for (j = 0; j < 4; j = j + 1)
            if (plane_wr_en[j])
                mem[wr_addr][8*j +: 8] <= plane_wdata[8*j +: 8];
    end
endmodule

// File: dv/pgd_datapath_test.sv
`timescale 1ns/1ps
module pgd_datapath_test;
    reg clk_sys = 0, srst = 1, io_wr = 0, mem_rd = 0, mem_wr = 0;
    reg [9:0] io_addr = 0;
    reg [7:0] io_wdata = 0, cpu_wdata = 0, d, msk, mode, misc, pa;
    reg [15:0] cpu_addr = 0, a;
    reg [63:0] rr;
    reg [31:0] lat;
    reg [3:0] fv, fe, cc, ign;
    reg [2:0] rot, sel;
    reg [1:0] wm, fn;
    wire [31:0] plane_rdata, plane_wdata;
    wire [7:0] cpu_rdata, bus_a, bus_b;
    wire [15:0] plane_addr;
    wire [3:0] plane_wr_en, colour;
    wire cpu_rvalid, map0, map1, shift;
    integer fail_count = 0, tests_run = 0, cycles = 0, n;
    localparam [31:0] MODES = 32'h03001004;
    localparam [31:0] MISCS = 32'h00020000;
    localparam [63:0] ADDRS = 64'h0001800200030002;
    localparam [63:0] EXPA = 64'h0001800300030002;
    localparam [15:0] ENS = 16'h05A5;

    pgd_datapath #(.ADDR_W(16)) DUT (.clk_sys, .srst, .io_wr, .io_addr,
        .io_wdata, .mem_rd, .mem_wr, .cpu_addr, .cpu_wdata, .cpu_rdata,
        .cpu_rvalid, .plane_rdata, .plane_wdata, .plane_wr_en, .plane_addr,
        .plane_pair_a_address_bus(bus_a), .plane_pair_b_address_bus(bus_b),
        .memory_map_select_0(map0), .memory_map_select_1(map1),
        .interleave_shift(shift), .internal_plane_color_signals(colour));
    pgd_plane_mem u_mem (.clk_sys, .mem_rd, .rd_addr(cpu_addr[3:0]),
        .plane_wr_en, .wr_addr(plane_addr[3:0]), .plane_wdata, .plane_rdata);

    // Clock and cycle ceiling
    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end

    task print_verdict;
        begin
            $display("Checks %0d, mismatches %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("ERROR t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task port(input [9:0] ad, input [7:0] v);
        begin
            @(posedge clk_sys);
            #2 io_wr = 1;
            io_addr = ad;
            io_wdata = v;
            @(posedge clk_sys);
            #2 io_wr = 0;
        end
    endtask
    // Index write then data write
    task wreg(input [3:0] idx, input [7:0] v);
        begin
            port(10'h3CE, {4'h0, idx});
            port(10'h3CF, v);
        end
    endtask
    task acc(input w, input [15:0] ad, input [7:0] v);
        begin
            @(posedge clk_sys);
            #2 mem_rd = !w;
            mem_wr = w;
            cpu_addr = ad;
            cpu_wdata = v;
            @(posedge clk_sys);
            #2 mem_rd = 0;
            mem_wr = 0;
            chk(cpu_rvalid, !w);
        end
    endtask
    // Plane bytes after a write, from the latched bytes
    function [31:0] exp_wr(input [31:0] l);
        reg [7:0] s, f, lb;
        reg [15:0] r2;
        integer p;
        begin
            r2 = {d, d} << rot;
            for (p = 0; p < 4; p = p + 1) begin
                lb = l[8*p +: 8];
                s = (wm == 2) ? {8{d[p]}} : fe[p] ? {8{fv[p]}} : r2[15:8];
                case (fn)
                    2'h0: f = s;
                    2'h1: f = s & lb;
                    2'h2: f = s | lb;
                    default: f = s ^ lb;
                endcase
                exp_wr[8*p +: 8] = (wm == 1) ? lb : (f & msk) | (lb & ~msk);
            end
        end
    endfunction
    // Byte returned by a read, plane select or colour compare
    function [7:0] exp_rd(input [31:0] l, input cmp);
        integer p, i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                exp_rd[i] = 1'b1;
                for (p = 0; p < 4; p = p + 1)
                    if (!ign[p] && l[8*p+i] != cc[p])
                        exp_rd[i] = 1'b0;
            end
            if (!cmp)
                exp_rd = sel[2] ? 8'h00 : l[8*sel[1:0] +: 8];
        end
    endfunction

    // Main sequence
    initial begin
        n = $urandom(32'h754FF8DA);
        pa = 8'h00;
        repeat (8) @(posedge clk_sys);
        #2 srst = 0;
        port(10'h3CC, 8'h00);
        port(10'h3CA, 8'h01);
        for (n = 0; n < 200; n = n + 1) begin
            rr = {$urandom, $urandom};
            {d, msk, rot, fn, fv, fe, cc, ign, sel} = rr[39:0];
            wm = rr[41:40] % 3;
            mode = {2'b00, rr[42], 1'b0, rr[43], 1'b0, wm};
            misc = {4'h0, rr[45:44], 1'b0, rr[46]};
            a = {12'h000, rr[50:47]};
            wreg(4'h0, {4'h0, fv});
            wreg(4'h1, {4'h0, fe});
            wreg(4'h2, {4'h0, cc});
            wreg(4'h3, {3'h0, fn, rot});
            wreg(4'h4, {5'h00, sel});
            wreg(4'h5, mode);
            wreg(4'h6, misc);
            wreg(4'h7, {4'h0, ign});
            wreg(4'h8, msk);
            chk({map1, map0, shift, colour}, {misc[3:2], mode[5], cc});
            lat = u_mem.mem[a[3:0]];
            acc(0, a, 8'h00);
            chk(cpu_rdata, exp_rd(lat, mode[3]));
            chk(bus_b, misc[0] ? bus_a : pa);
            acc(1, a, d);
            chk(plane_wr_en, 4'hF);
            chk(plane_wdata, exp_wr(lat));
            pa = a[7:0];
        end
        // Swapped section positions, then a refused index
        port(10'h3CC, 8'h01);
        port(10'h3CA, 8'h00);
        wreg(4'h5, 8'h00);
        wreg(4'h3, 8'h00);
        wreg(4'h8, 8'hFF);
        wreg(4'h1, 8'h0F);
        wreg(4'h0, 8'h03);
        wreg(4'h9, 8'h00);
        acc(1, 16'h0000, 8'h5A);
        chk(plane_wdata, 32'hFFFF0000);
        port(10'h3CC, 8'h00);
        port(10'h3CA, 8'h01);
        // Test, odd/even, chain and invalid write mode
        for (n = 0; n < 4; n = n + 1) begin
            wreg(4'h5, MODES[8*n +: 8]);
            wreg(4'h6, MISCS[8*n +: 8]);
            acc(1, ADDRS[16*n +: 16], 8'hC3);
            chk(plane_wr_en, ENS[4*n +: 4]);
            chk(plane_addr, EXPA[16*n +: 16]);
            chk(colour, (n == 0) ? 4'hF : cc);
        end
        print_verdict;
    end
endmodule
